// ==== verilog/lie_defs.svh ====
`ifndef LIE_DEFS_SVH
`define LIE_DEFS_SVH

// ****************************************
// register offsets on the plain port
// ****************************************
`define LIE_OFS_INSTR 3'h0
`define LIE_OFS_DATA 3'h1
`define LIE_OFS_SERIAL 3'h2
`define LIE_OFS_SER_START 3'h3
`define LIE_OFS_CONFIG 3'h4

// ****************************************
// field positions
// ****************************************
`define LIE_CO_BIT 7
`define LIE_RS_BIT 6
`define LIE_EM_INC_BIT 1
`define LIE_EM_SHW_BIT 0
`define LIE_DC_ON_BIT 2
`define LIE_DC_CUR_BIT 1
`define LIE_DC_FLASH_BIT 0
`define LIE_FS_DL_BIT 4
`define LIE_FS_M_BIT 2
`define LIE_FS_SL_BIT 1
`define LIE_FS_H_BIT 0
`define LIE_VL_SEL_BIT 6

// ****************************************
// values and timing counts
// ****************************************
`define LIE_BLANK_CODE 8'h20
`define LIE_TEXT_DEPTH 80
`define LIE_BLINK_PERIOD 104448
`define LIE_EXEC_CYCLES 8'h03
`define LIE_CLEAR_CYCLES 8'ha5
`define LIE_CHARS_WIDE 5'h18
`define LIE_CHARS_NARROW 5'h0c
`define LIE_MUX_FULL 5'h12
`define LIE_MUX_SINGLE 5'h09
`define LIE_MUX_ICON 5'h02
`define LIE_CURSOR_DOT_LINE 3'h7
`define LIE_CURSOR_DOTS 5'h1f

`endif

// ==== verilog/lie_pkg.sv ====
`default_nettype none
package lie_pkg;

   typedef enum logic [1:0] {st_idle, st_exec, st_clear} lie_state_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lie_req_t;

   typedef struct packed {
      logic display_on;
      logic outputs_grounded;
      logic bias_gen_enable;
      logic cursor_underline;
      logic [2:0] cursor_dot_line;
      logic [4:0] cursor_dots;
      logic cursor_all_dots;
      logic two_line;
      logic [4:0] chars_per_line;
      logic [4:0] mux_ratio;
      logic half_mirror;
      logic col_reverse;
      logic row_reverse;
      logic icon_only;
      logic icon_flash_enable;
      logic direct_drive_enable;
      logic extended;
      logic [6:0] display_shift;
   } lie_disp_t;

endpackage
`default_nettype wire

// ==== verilog/lie_executor.sv ====
// Contract
// - serial control byte bit 7 set means another control byte follows the next byte.
// - two-line bit picks 1x24 or 2x12 layout, ignored when single-line mux set.
// - single-line mux bit picks 1:18 rate, or 1:9 with one 12-char line.
// - extended-select bit switches decoding between basic and extended instruction sets.
// - mirror bit reverses 12-char halves to columns 60..1, ignored in two-line or single-line.
// - column-reverse bit outputs columns 1..60 or 60..1.
// - row-reverse bit gives rows 1..16 with icons 17,18, or 16..1 with 18,17.
// - icon-only bit selects icon display; separate bits enable icon flash and direct drive.
// - clear display writes code 20h into every text RAM location.
// - clear zeroes address counter, cancels shift, forces increment, keeps shift-on-write.
// - return home zeroes counter and shift, keeps RAM, direction and shift-on-write.
// - each data write or read moves the address counter by one per direction bit.
// - cursor underline and cursor flash are suppressed while glyph RAM is addressed.
// - shift-on-write shifts display on text writes, right when decrementing, left when incrementing.
// - no display shift on text reads or on any glyph RAM access.
// - display-on bit blanks or shows output, text RAM kept so image returns at once.
// - display off grounds outputs, stops generators, instructions still execute.
// - visible cursor is five dots on the eighth dot line; entry functions continue.
// - cursor flash alternates character and all dots at oscillator over 104448.
// - underline and flash may be enabled and shown together.
// - entry mode has direction in bit 1, shift-on-write in bit 0, bit 2 set.
// - display control has on, cursor, flash in bits 2..0, bit 3 set.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lie_defs.svh"

module lie_executor
   import lie_pkg::*;
#(
   parameter int TEXT_DEPTH = `LIE_TEXT_DEPTH,
   parameter int BLINK_PERIOD = `LIE_BLINK_PERIOD
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire lie_req_t bus_req,
   output logic [7:0] bus_rdata,
   output logic busy_flag,
   output logic [6:0] address_counter,
   output lie_disp_t disp,
   output logic bus_width_select,
   output logic [5:0] lcd_level_slot_a,
   output logic [5:0] lcd_level_slot_b,
   input wire logic [6:0] scan_addr,
   output logic [7:0] scan_char
);

   // ****************************************
   // state
   // ****************************************
   lie_state_t state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [6:0] clr_idx_ff;
   logic busy_flag_ff;
   logic [6:0] ac_ff, nxt_ac;
   logic [6:0] shift_ff, nxt_shift;
   logic cg_sel_ff, inc_ff, shw_ff;
   logic d_on_ff, cur_ff, flash_ff;
   logic m_ff, sl_ff, h_ff, dl_ff;
   logic mirror_ff, p_ff, q_ff, im_ff, ib_ff, dm_ff;
   logic [5:0] lvl_a_ff, lvl_b_ff;
   logic [7:0] dr_ff;
   logic dr_reload_ff;
   logic [16:0] blink_cnt_ff;
   logic blink_ff;
   logic [7:0] rdata_ff, scan_ff;
   lie_disp_t disp_ff, nxt_disp;
   logic expect_ctrl_ff, rs_hold_ff, last_ctrl_ff;
   logic [7:0] text_ram [TEXT_DEPTH];
   logic [4:0] glyph_ram [128];

   // ****************************************
   // bus decode
   // ****************************************
   wire [7:0] wd = bus_req.wdata;
   wire wr_instr = bus_req.wr && bus_req.addr == `LIE_OFS_INSTR;
   wire wr_data = bus_req.wr && bus_req.addr == `LIE_OFS_DATA;
   wire wr_ser = bus_req.wr && bus_req.addr == `LIE_OFS_SERIAL;
   wire wr_ser_start = bus_req.wr && bus_req.addr == `LIE_OFS_SER_START;
   wire rd_status = bus_req.rd && bus_req.addr == `LIE_OFS_INSTR;
   wire rd_data = bus_req.rd && bus_req.addr == `LIE_OFS_DATA;
   wire rd_config = bus_req.rd && bus_req.addr == `LIE_OFS_CONFIG;

   // a serial byte after a control byte carries its register select
   wire ser_issue = wr_ser && !expect_ctrl_ff;
   wire cmd_valid = wr_instr || wr_data || ser_issue;
   wire cmd_rs = wr_data || (ser_issue && rs_hold_ff);
   wire idle = state_ff == st_idle;
   wire acc = idle && (cmd_valid || rd_data);
   wire acc_instr = acc && cmd_valid && !cmd_rs;
   wire acc_wr = acc && cmd_valid && cmd_rs;
   wire acc_rd = acc && rd_data;

   // ****************************************
   // instruction decode
   // ****************************************
   // basic or extended set
   wire basic = !h_ff;
   wire is_clear = acc_instr && basic && wd == 8'h01;
   wire is_home = acc_instr && basic && wd[7:1] == 7'h01;
   wire is_entry = acc_instr && basic && wd[7:2] == 6'h01;
   wire is_dctl = acc_instr && basic && wd[7:3] == 5'h01;
   wire is_cg = acc_instr && basic && wd[7:6] == 2'h1;
   wire is_dd = acc_instr && basic && wd[7];
   wire is_fset = acc_instr && wd[7:5] == 3'h1;
   wire is_scr = acc_instr && h_ff && wd[7:1] == 7'h01;
   wire is_dcfg = acc_instr && h_ff && wd[7:2] == 6'h01;
   wire is_icon = acc_instr && h_ff && wd[7:3] == 5'h01;
   wire is_vlcd = acc_instr && h_ff && wd[7];

   wire ac_in_text = ac_ff < 7'(TEXT_DEPTH);
   wire [6:0] ac_step = inc_ff ? 7'h01 : 7'h7f;
   wire text_wr = acc_wr && !cg_sel_ff;
   wire clearing = state_ff == st_clear;
   wire [7:0] text_rd = ac_in_text ? text_ram[ac_ff] : 8'h00;
   wire [7:0] glyph_rd = {3'h0, glyph_ram[ac_ff]};

   // ****************************************
   // sequencing and busy
   // ****************************************
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         st_idle:
         begin
            if (acc)
            begin
               nxt_state = is_clear ? st_clear : st_exec;
               nxt_cnt = (is_clear ? `LIE_CLEAR_CYCLES : `LIE_EXEC_CYCLES) - 8'h01;
            end
         end
         st_exec, st_clear:
         begin
            if (cnt_ff == 8'h00)
               nxt_state = st_idle;
            else
               nxt_cnt = cnt_ff - 8'h01;
         end
      endcase
   end

   // busy for the full execution time
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_ff <= st_idle;
         cnt_ff <= 8'h00;
         busy_flag_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         busy_flag_ff <= nxt_state != st_idle;
      end
   end

   // blank sweep over the text RAM
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         clr_idx_ff <= 7'h00;
      else if (clk_en)
      begin
         if (is_clear)
            clr_idx_ff <= 7'h00;
         else if (clearing && clr_idx_ff != 7'(TEXT_DEPTH - 1))
            clr_idx_ff <= clr_idx_ff + 7'h01;
      end
   end

   // ****************************************
   // memories
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (clk_en)
      begin
         if (clearing)
            text_ram[clr_idx_ff] <= `LIE_BLANK_CODE;
         else if (text_wr && ac_in_text)
            text_ram[ac_ff] <= wd;
         if (acc_wr && cg_sel_ff)
            glyph_ram[ac_ff] <= wd[4:0];
      end
   end

   // ****************************************
   // address counter and shift
   // ****************************************
   always_comb
   begin
      nxt_ac = ac_ff;
      nxt_shift = shift_ff;
      if (is_clear || is_home)
      begin
         nxt_ac = 7'h00;
         nxt_shift = 7'h00;
      end
      else if (is_cg)
         nxt_ac = {ac_ff[6], wd[5:0]};
      else if (is_dd)
         nxt_ac = wd[6:0];
      else if (acc_wr || acc_rd)
         nxt_ac = ac_ff + ac_step;
      // reads and glyph access never shift
      if (text_wr && shw_ff)
         nxt_shift = inc_ff ? shift_ff - 7'h01 : shift_ff + 7'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ac_ff <= 7'h00;
         shift_ff <= 7'h00;
         cg_sel_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         ac_ff <= nxt_ac;
         shift_ff <= nxt_shift;
         if (is_cg || is_dd)
            cg_sel_ff <= is_cg;
      end
   end

   // data register reloads from the new address one cycle after the change
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dr_ff <= 8'h00;
         dr_reload_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         dr_reload_ff <= is_cg || is_dd || acc_rd;
         if (dr_reload_ff)
            dr_ff <= cg_sel_ff ? glyph_rd : text_rd;
      end
   end

   // ****************************************
   // mode bits
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         inc_ff <= 1'b1;
         shw_ff <= 1'b0;
         d_on_ff <= 1'b0;
         cur_ff <= 1'b0;
         flash_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (is_clear)
            inc_ff <= 1'b1;
         else if (is_entry)
         begin
            inc_ff <= wd[`LIE_EM_INC_BIT];
            shw_ff <= wd[`LIE_EM_SHW_BIT];
         end
         if (is_dctl)
         begin
            d_on_ff <= wd[`LIE_DC_ON_BIT];
            cur_ff <= wd[`LIE_DC_CUR_BIT];
            flash_ff <= wd[`LIE_DC_FLASH_BIT];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         {dl_ff, m_ff, sl_ff, h_ff} <= 4'h8;
         {mirror_ff, p_ff, q_ff} <= 3'h0;
         {im_ff, ib_ff, dm_ff} <= 3'h0;
         lvl_a_ff <= 6'h00;
         lvl_b_ff <= 6'h00;
      end
      else if (clk_en)
      begin
         if (is_fset)
         begin
            dl_ff <= wd[`LIE_FS_DL_BIT];
            m_ff <= wd[`LIE_FS_M_BIT];
            sl_ff <= wd[`LIE_FS_SL_BIT];
            h_ff <= wd[`LIE_FS_H_BIT];
         end
         if (is_scr)
            mirror_ff <= wd[0];
         if (is_dcfg)
            {p_ff, q_ff} <= wd[1:0];
         // icon mode, icon flash, direct drive
         if (is_icon)
            {im_ff, ib_ff, dm_ff} <= wd[2:0];
         if (is_vlcd && !wd[`LIE_VL_SEL_BIT])
            lvl_a_ff <= wd[5:0];
         if (is_vlcd && wd[`LIE_VL_SEL_BIT])
            lvl_b_ff <= wd[5:0];
      end
   end

   // ****************************************
   // serial control byte parser
   // ****************************************
   // continuation flag decides what follows the next byte
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         expect_ctrl_ff <= 1'b1;
         rs_hold_ff <= 1'b0;
         last_ctrl_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_ser_start)
         begin
            expect_ctrl_ff <= 1'b1;
            last_ctrl_ff <= 1'b0;
         end
         else if (wr_ser && expect_ctrl_ff)
         begin
            rs_hold_ff <= wd[`LIE_RS_BIT];
            last_ctrl_ff <= !wd[`LIE_CO_BIT];
            expect_ctrl_ff <= 1'b0;
         end
         else if (wr_ser)
            expect_ctrl_ff <= !last_ctrl_ff;
      end
   end

   // ****************************************
   // cursor flash timebase
   // ****************************************
   // phase toggles every half flash period
   wire blink_half = blink_cnt_ff == 17'(BLINK_PERIOD / 2 - 1);
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         blink_cnt_ff <= 17'h00000;
         blink_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         blink_cnt_ff <= blink_half ? 17'h00000 : blink_cnt_ff + 17'h00001;
         if (blink_half)
            blink_ff <= !blink_ff;
      end
   end

   // ****************************************
   // display configuration outputs
   // ****************************************
   always_comb
   begin
      nxt_disp = '0;
      nxt_disp.display_on = d_on_ff;
      nxt_disp.outputs_grounded = !d_on_ff;
      nxt_disp.bias_gen_enable = d_on_ff;
      // five dots on the eighth line
      nxt_disp.cursor_underline = d_on_ff && cur_ff && !cg_sel_ff;
      nxt_disp.cursor_dot_line = `LIE_CURSOR_DOT_LINE;
      nxt_disp.cursor_dots = `LIE_CURSOR_DOTS;
      nxt_disp.cursor_all_dots = d_on_ff && flash_ff && !cg_sel_ff && blink_ff;
      nxt_disp.two_line = m_ff && !sl_ff;
      nxt_disp.chars_per_line = (m_ff || sl_ff) ? `LIE_CHARS_NARROW : `LIE_CHARS_WIDE;
      nxt_disp.mux_ratio = im_ff ? `LIE_MUX_ICON : (sl_ff ? `LIE_MUX_SINGLE : `LIE_MUX_FULL);
      // mirror only in one-line 24-character mode
      nxt_disp.half_mirror = mirror_ff && !m_ff && !sl_ff;
      nxt_disp.col_reverse = p_ff;
      nxt_disp.row_reverse = q_ff;
      nxt_disp.icon_only = im_ff;
      nxt_disp.icon_flash_enable = ib_ff;
      nxt_disp.direct_drive_enable = dm_ff;
      nxt_disp.extended = h_ff;
      nxt_disp.display_shift = shift_ff;
   end

   wire [7:0] cfg_word = {cg_sel_ff, d_on_ff, cur_ff, flash_ff, inc_ff, shw_ff, sl_ff, h_ff};
   wire [7:0] nxt_rdata = rd_status ? {busy_flag_ff, ac_ff} :
                          rd_data ? dr_ff :
                          rd_config ? cfg_word : 8'h00;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_ff <= 8'h00;
         disp_ff <= '0;
         scan_ff <= 8'h00;
      end
      else if (clk_en)
      begin
         rdata_ff <= nxt_rdata;
         disp_ff <= nxt_disp;
         scan_ff <= scan_addr < 7'(TEXT_DEPTH) ? text_ram[scan_addr] : 8'h00;
      end
   end

   assign bus_rdata = rdata_ff;
   assign busy_flag = busy_flag_ff;
   assign address_counter = ac_ff;
   assign disp = disp_ff;
   assign bus_width_select = dl_ff;
   assign lcd_level_slot_a = lvl_a_ff;
   assign lcd_level_slot_b = lvl_b_ff;
   assign scan_char = scan_ff;

   // ****************************************
   // checks
   // ****************************************
   a_clear_busy: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      is_clear |-> ##165 busy_flag_ff ##1 !busy_flag_ff)
      else $error("clear busy time wrong");
   a_exec_busy: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      acc && !is_clear |=> busy_flag_ff [*3] ##1 !busy_flag_ff)
      else $error("instruction busy time wrong");
   a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      busy_flag_ff && cmd_valid |=> $stable(ac_ff) && $stable(inc_ff))
      else $error("instruction taken while busy");
   a_clear_state: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      is_clear |=> ac_ff == 7'h00 && shift_ff == 7'h00 && inc_ff && shw_ff == $past(shw_ff))
      else $error("clear left wrong state");
   a_home_keep: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      is_home |=> ac_ff == 7'h00 && shift_ff == 7'h00 && $stable(inc_ff) && $stable(shw_ff))
      else $error("home changed wrong state");
   a_ac_step: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      acc_wr || acc_rd |=> ac_ff == $past(ac_ff) + ($past(inc_ff) ? 7'h01 : 7'h7f))
      else $error("address counter step wrong");
   a_shift_write: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      text_wr && shw_ff |=> shift_ff == $past(shift_ff) + ($past(inc_ff) ? 7'h7f : 7'h01))
      else $error("display shift on write wrong");
   a_no_shift_rd: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      acc_rd || (acc_wr && cg_sel_ff) |=> $stable(shift_ff))
      else $error("display shifted on read or glyph access");
   a_glyph_cursor: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      cg_sel_ff ##1 cg_sel_ff |-> !disp_ff.cursor_underline && !disp_ff.cursor_all_dots)
      else $error("cursor shown during glyph access");
   a_power_down: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      rst_n && !d_on_ff |=> disp_ff.outputs_grounded && !disp_ff.bias_gen_enable)
      else $error("outputs not grounded with display off");
   a_mirror_gate: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
      m_ff || sl_ff |=> !disp_ff.half_mirror)
      else $error("mirror active outside one-line mode");

endmodule
`default_nettype wire

// ==== tb/lie_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lie_host
   import lie_pkg::*;
(
   input wire logic clk,
   input wire logic busy_flag,
   input wire logic [7:0] bus_rdata,
   output lie_req_t bus_req
);
   initial bus_req = '0;

   // data lines show the inverse once a write is over
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= '{a, ~d, 1'b0, 1'b0};
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      @(posedge clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      q = bus_rdata;
   endtask

   task automatic idle(output int n);
      n = 0;
      #1;
      // a busy flag that never drops is left to the watchdog, which fails the run
      while (busy_flag !== 1'b0)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/lie_executor_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module lie_executor_tb
   import lie_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] scan_addr = 7'h00;
   lie_req_t bus_req;
   logic [7:0] bus_rdata, scan_char, q;
   logic busy_flag, bus_width_select;
   logic [5:0] lvl_a, lvl_b;
   logic [6:0] address_counter;
   lie_disp_t disp;
   int failures = 0;
   int total_checks = 0;
   int n, hi;

   initial
   begin
      forever #4 clk = ~clk;
   end

   lie_host u_lie_host (.clk(clk), .busy_flag(busy_flag), .bus_rdata(bus_rdata), .bus_req(bus_req));

   lie_executor #(.BLINK_PERIOD(16)) u_lie_executor (
      .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .busy_flag(busy_flag), .address_counter(address_counter), .disp(disp),
      .bus_width_select(bus_width_select), .lcd_level_slot_a(lvl_a), .lcd_level_slot_b(lvl_b),
      .scan_addr(scan_addr), .scan_char(scan_char));

   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask

   task automatic ins(input logic [7:0] d);
      u_lie_host.wr(3'h0, d);
      u_lie_host.idle(n);
   endtask

   task automatic dat(input logic [7:0] d);
      u_lie_host.wr(3'h1, d);
      u_lie_host.idle(n);
   endtask

   task automatic scan(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      scan_addr <= a;
      @(posedge clk);
      #1;
      chk("scan_char", e, scan_char);
   endtask

   task automatic t_reset();
      chk("chars", 16'h18, disp.chars_per_line);
      chk("mux", 16'h12, disp.mux_ratio);
      chk("grounded", 1, disp.outputs_grounded);
      chk("ac", 0, address_counter);
      chk("dl", 1, bus_width_select);
      $display("reset test done");
   endtask

   task automatic t_entry();
      ins(8'h80);
      ins(8'h06);
      dat(8'h41);
      chk("ac", 1, address_counter);
      chk("shift", 0, disp.display_shift);
      ins(8'h07);
      dat(8'h42);
      chk("shift", 16'h7f, disp.display_shift);
      ins(8'h05);
      dat(8'h43);
      chk("ac", 1, address_counter);
      chk("shift", 0, disp.display_shift);
      u_lie_host.rd(3'h1, q);
      u_lie_host.idle(n);
      chk("ac", 0, address_counter);
      chk("shift", 0, disp.display_shift);
      $display("entry test done");
   endtask

   task automatic t_home();
      ins(8'h07);
      dat(8'h44);
      ins(8'h02);
      chk("ac", 0, address_counter);
      chk("shift", 0, disp.display_shift);
      u_lie_host.rd(3'h4, q);
      chk("inc_shw", 2'b11, q[3:2]);
      scan(7'h00, 8'h44);
      $display("home test done");
   endtask

   task automatic t_clear();
      ins(8'h04);
      ins(8'hcf);
      dat(8'h55);
      u_lie_host.wr(3'h0, 8'h01);
      u_lie_host.idle(n);
      chk("clear busy", 165, n);
      chk("ac", 0, address_counter);
      u_lie_host.rd(3'h4, q);
      chk("inc_shw", 2'b10, q[3:2]);
      scan(7'h4f, 8'h20);
      scan(7'h00, 8'h20);
      $display("clear test done");
   endtask

   task automatic t_dctl();
      ins(8'h0f);
      chk("on", 1, disp.display_on);
      chk("bias", 1, disp.bias_gen_enable);
      chk("underline", 1, disp.cursor_underline);
      chk("dots", {3'h7, 5'h1f}, {disp.cursor_dot_line, disp.cursor_dots});
      hi = 0;
      repeat (64)
      begin
         @(posedge clk);
         #1;
         if (disp.cursor_all_dots === 1'b1)
            hi++;
      end
      // 64 cycles are four whole flash periods of 16, so exactly half show all dots
      chk("flash", 32, hi);
      chk("underline", 1, disp.cursor_underline);
      ins(8'h40);
      chk("underline", 0, disp.cursor_underline);
      chk("all dots", 0, disp.cursor_all_dots);
      ins(8'h08);
      repeat (3) @(posedge clk);
      #1;
      chk("grounded", 1, disp.outputs_grounded);
      chk("bias", 0, disp.bias_gen_enable);
      scan(7'h4f, 8'h20);
      ins(8'h0c);
      chk("on", 1, disp.display_on);
      $display("display test done");
   endtask

   task automatic t_fset();
      ins(8'h24);
      chk("two", 16'h10c, {disp.two_line, 3'h0, disp.chars_per_line});
      chk("dl", 0, bus_width_select);
      ins(8'h26);
      chk("sl", 16'h0c09, {disp.two_line, disp.chars_per_line, 3'h0, disp.mux_ratio});
      ins(8'h21);
      chk("ext", 1, disp.extended);
      ins(8'h03);
      chk("mirror", 1, disp.half_mirror);
      ins(8'h07);
      chk("rev", 2'b11, {disp.col_reverse, disp.row_reverse});
      ins(8'h0f);
      chk("icon", 3'b111, {disp.icon_only, disp.icon_flash_enable, disp.direct_drive_enable});
      chk("mux", 16'h02, disp.mux_ratio);
      chk("on", 1, disp.display_on);
      ins(8'h95);
      ins(8'hca);
      chk("level a", 16'h15, lvl_a);
      chk("level b", 16'h0a, lvl_b);
      ins(8'h24);
      chk("ext", 0, disp.extended);
      chk("mirror", 0, disp.half_mirror);
      $display("config test done");
   endtask

   task automatic t_serial();
      u_lie_host.wr(3'h3, 8'h00);
      u_lie_host.wr(3'h2, 8'h80);
      u_lie_host.wr(3'h2, 8'h08);
      u_lie_host.idle(n);
      u_lie_host.wr(3'h2, 8'h80);
      u_lie_host.wr(3'h2, 8'h85);
      u_lie_host.idle(n);
      u_lie_host.wr(3'h2, 8'h40);
      u_lie_host.wr(3'h2, 8'h61);
      u_lie_host.idle(n);
      u_lie_host.wr(3'h2, 8'h62);
      u_lie_host.idle(n);
      chk("on", 0, disp.display_on);
      scan(7'h05, 8'h61);
      scan(7'h06, 8'h62);
      ins(8'h85);
      u_lie_host.rd(3'h1, q);
      u_lie_host.idle(n);
      chk("read data", 16'h61, q);
      u_lie_host.rd(3'h0, q);
      chk("status", 16'h06, q);
      // the second write lands while busy and must be dropped
      u_lie_host.wr(3'h1, 8'h77);
      u_lie_host.wr(3'h1, 8'h78);
      u_lie_host.idle(n);
      chk("ac", 16'h07, address_counter);
      scan(7'h06, 8'h77);
      scan(7'h07, 8'h20);
      $display("serial test done");
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #200000;
      failures++;
      summarize();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_entry();
      t_home();
      t_clear();
      t_dctl();
      t_fset();
      t_serial();
      summarize();
   end
endmodule
`default_nettype wire
